// File: rtl/serial_eeprom_config_pkg.sv
package serial_eeprom_config_pkg;

	// ==========================================================
	// clock and serial timing
	localparam int CLOCK_HZ    = 50_000_000;
	localparam int SK_RATE_HZ  = 1_000_000;
	localparam int HALF_CYCLES = CLOCK_HZ / (2 * SK_RATE_HZ);
	localparam int PHASE_W     = 5;
	localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(HALF_CYCLES - 1);

	// ==========================================================
	// command framing: start bit, read opcode, word address
	localparam int         ADDR_BITS   = 6;
	localparam int         CMD_BITS    = 9;
	localparam logic       START_BIT   = 1'b1;
	localparam logic [1:0] READ_OPCODE = 2'h2;
	localparam int         SLOT_W      = 5;
	localparam logic [SLOT_W-1:0] CMD_LAST  = 5'h08;
	localparam logic [SLOT_W-1:0] ACK_SLOT  = 5'h09;
	localparam logic [SLOT_W-1:0] LAST_SLOT = 5'h19;

	// ==========================================================
	// stored configuration
	localparam int WORD_BITS    = 16;
	localparam int CONFIG_WORDS = 4;
	localparam int WORD_IDX_W   = 2;
	localparam logic [WORD_IDX_W-1:0] WORD_LAST = 2'h3;
	localparam logic [WORD_BITS-1:0]  VALID_MARKER = 16'hA55A;

	typedef struct packed {
		logic [WORD_BITS-1:0] marker;
		logic [WORD_BITS-1:0] options;
		logic [WORD_BITS-1:0] power;
		logic [WORD_BITS-1:0] timeout;
	} config_type;

	localparam config_type DEFAULT_CONFIG = '{
		marker:  16'h0000,
		options: 16'h0000,
		power:   16'h0032,
		timeout: 16'h0010
	};

	typedef struct packed {
		logic select;
		logic clock;
		logic data;
		logic data_oe;
	} memory_pins_type;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_SHIFT = 3'h2,
		ST_DONE  = 3'h4
	} state_type;

endpackage : serial_eeprom_config_pkg

// File: rtl/sync_stage.sv
`timescale 1ns/1ns
module sync_stage #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clock,
	input  wire logic             i_rst_b,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_reg;

	// ==========================================================
	// two flops; first one is read by the second only
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			meta_reg <= '0;
			o_sync   <= '0;
		end else begin
			meta_reg <= i_async;
			o_sync   <= meta_reg;
		end
	end
endmodule : sync_stage

// File: rtl/serial_eeprom_config_loader.sv
// Operation
// - scan memory after power-on and bus reset
// - use stored words if valid, else defaults
// - high during acknowledge means absent memory
// - read sixteen-bit words only
// - memory pins undriven while in reset
// - fifo pins undriven while in reset
// - pull-up drive low while reset low
`timescale 1ns/1ns
module serial_eeprom_config_loader
	import serial_eeprom_config_pkg::*;
(
	input  wire logic  i_clock,
	input  wire logic  i_rst_b,
	input  wire logic  i_bus_reset,
	input  wire logic  i_memory_serial_line,
	output logic       o_memory_serial_line,
	output logic       o_memory_serial_line_oe,
	output logic       o_memory_select_out,
	output logic       o_memory_select_out_oe,
	output logic       o_memory_serial_clock,
	output logic       o_memory_serial_clock_oe,
	output logic       o_pullup_drive_output_n,
	output logic       o_fifo_drive_enable,
	output config_type o_config,
	output logic       o_config_from_memory,
	output logic       o_load_done
);
	// ==========================================================
	// input synchronisers
	logic [1:0] pin_sync;
	logic       line_sync;
	logic       bus_reset_sync;
	logic       bus_reset_seen_reg;
	logic       bus_rise;

	sync_stage #(.WIDTH(2)) u_pin_sync (
		.i_clock (i_clock),
		.i_rst_b (i_rst_b),
		.i_async ({i_memory_serial_line, i_bus_reset}),
		.o_sync  (pin_sync)
	);

	assign line_sync      = pin_sync[1];
	assign bus_reset_sync = pin_sync[0];

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			bus_reset_seen_reg <= 1'b0;
		end else begin
			bus_reset_seen_reg <= bus_reset_sync;
		end
	end

	assign bus_rise = bus_reset_sync & ~bus_reset_seen_reg;

	// ==========================================================
	// bit-slot timing: one half period per phase
	logic [PHASE_W-1:0] phase_reg;
	logic               tick;

	assign tick = (phase_reg == PHASE_LAST);

	always_ff @(posedge i_clock) begin
		if (!i_rst_b || bus_rise || tick) begin
			phase_reg <= '0;
		end else begin
			phase_reg <= phase_reg + PHASE_W'(1);
		end
	end

	// ==========================================================
	// command word and next output bit
	state_type            state_reg;
	logic [SLOT_W-1:0]    slot_reg;
	logic [SLOT_W-1:0]    slot_next;
	logic [WORD_IDX_W-1:0] word_reg;
	logic [CMD_BITS-1:0]  cmd_vec;
	logic                 cmd_bit_next;
	logic                 cmd_oe_next;

	assign cmd_vec = {START_BIT, READ_OPCODE,
		ADDR_BITS'(word_reg)};
	assign slot_next = slot_reg + SLOT_W'(1);

	always_comb begin
		cmd_oe_next  = (slot_next <= CMD_LAST);
		cmd_bit_next = 1'b0;
		if (cmd_oe_next) begin
			cmd_bit_next = cmd_vec[CMD_LAST[3:0] - slot_next[3:0]];
		end
	end

	// ==========================================================
	// read sequencer
	memory_pins_type      pins_reg;
	logic                 high_reg;
	logic                 absent_reg;
	logic [WORD_BITS-1:0] shift_reg;
	logic [WORD_BITS-1:0] mem [CONFIG_WORDS];
	logic                 store;

	assign store = (state_reg == ST_SHIFT) && tick && high_reg
		&& (slot_reg == LAST_SLOT);

	// restart on every release of reset and every bus reset
	always_ff @(posedge i_clock) begin
		if (!i_rst_b || bus_rise) begin
			state_reg  <= ST_IDLE;
			slot_reg   <= '0;
			word_reg   <= '0;
			high_reg   <= 1'b0;
			absent_reg <= 1'b0;
			shift_reg  <= '0;
			pins_reg   <= '0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					// one half period with select low between words
					if (tick) begin
						state_reg        <= ST_SHIFT;
						slot_reg         <= '0;
						high_reg         <= 1'b0;
						pins_reg.select  <= 1'b1;
						pins_reg.data    <= cmd_vec[CMD_LAST[3:0]];
						pins_reg.data_oe <= 1'b1;
					end
				end
				ST_SHIFT: begin
					if (tick && !high_reg) begin
						// sample at end of low phase, before next rise
						high_reg       <= 1'b1;
						pins_reg.clock <= 1'b1;
						if (slot_reg == ACK_SLOT && line_sync) begin
							absent_reg      <= 1'b1;
							state_reg       <= ST_DONE;
							high_reg        <= 1'b0;
							pins_reg.clock  <= 1'b0;
							pins_reg.select <= 1'b0;
						end else if (slot_reg > ACK_SLOT) begin
							shift_reg <= {shift_reg[WORD_BITS-2:0],
								line_sync};
						end
					end else if (tick) begin
						high_reg       <= 1'b0;
						pins_reg.clock <= 1'b0;
						if (slot_reg == LAST_SLOT) begin
							pins_reg.select <= 1'b0;
							slot_reg        <= '0;
							if (word_reg == WORD_LAST) begin
								state_reg <= ST_DONE;
							end else begin
								word_reg  <= word_reg + WORD_IDX_W'(1);
								state_reg <= ST_IDLE;
							end
						end else begin
							slot_reg         <= slot_next;
							pins_reg.data    <= cmd_bit_next;
							// release the shared line for ack and data
							pins_reg.data_oe <= cmd_oe_next;
						end
					end
				end
				ST_DONE: begin
					pins_reg <= '0;
				end
			endcase
		end
	end

	// word storage needs no reset; validity is judged on completion
	always_ff @(posedge i_clock) begin
		if (store) begin
			mem[word_reg] <= shift_reg;
		end
	end

	// ==========================================================
	// configuration result
	logic done_seen_reg;
	logic finish;
	logic stored_ok;

	assign finish    = (state_reg == ST_DONE) && !done_seen_reg;
	assign stored_ok = !absent_reg && (mem[0] == VALID_MARKER);

	always_ff @(posedge i_clock) begin
		if (!i_rst_b || bus_rise) begin
			done_seen_reg <= 1'b0;
		end else begin
			done_seen_reg <= (state_reg == ST_DONE);
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_config             <= DEFAULT_CONFIG;
			o_config_from_memory <= 1'b0;
			o_load_done          <= 1'b0;
		end else if (bus_rise) begin
			o_load_done <= 1'b0;
		end else if (finish) begin
			o_load_done          <= 1'b1;
			o_config_from_memory <= stored_ok;
			if (stored_ok) begin
				o_config <= {mem[0], mem[1], mem[2], mem[3]};
			end else begin
				o_config <= DEFAULT_CONFIG;
			end
		end
	end

	// ==========================================================
	// pin drivers; memory and fifo pins float and pull-up drive is low while reset is held
	logic drive_reg;

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			drive_reg               <= 1'b0;
			o_fifo_drive_enable     <= 1'b0;
			o_pullup_drive_output_n <= 1'b0;
		end else begin
			drive_reg               <= 1'b1;
			o_fifo_drive_enable     <= 1'b1;
			o_pullup_drive_output_n <= 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_memory_select_out      <= 1'b0;
			o_memory_select_out_oe   <= 1'b0;
			o_memory_serial_clock    <= 1'b0;
			o_memory_serial_clock_oe <= 1'b0;
			o_memory_serial_line     <= 1'b0;
			o_memory_serial_line_oe  <= 1'b0;
		end else begin
			o_memory_select_out      <= pins_reg.select;
			o_memory_select_out_oe   <= drive_reg;
			o_memory_serial_clock    <= pins_reg.clock;
			o_memory_serial_clock_oe <= drive_reg;
			o_memory_serial_line     <= pins_reg.data;
			o_memory_serial_line_oe  <= drive_reg & pins_reg.data_oe;
		end
	end
endmodule : serial_eeprom_config_loader

// File: tb/serial_eeprom_config_loader_assertions.sv
`timescale 1ns/1ns
module serial_eeprom_config_loader_checker
	import serial_eeprom_config_pkg::*;
(
	input wire logic       i_clock,
	input wire logic       i_rst_b,
	input wire logic       o_memory_serial_line,
	input wire logic       o_memory_serial_line_oe,
	input wire logic       o_memory_select_out,
	input wire logic       o_memory_select_out_oe,
	input wire logic       o_memory_serial_clock,
	input wire logic       o_memory_serial_clock_oe,
	input wire logic       o_pullup_drive_output_n,
	input wire logic       o_fifo_drive_enable,
	input wire config_type o_config,
	input wire logic       o_config_from_memory,
	input wire logic       o_load_done
);
	// ====================================================
	// pin release, framing and result
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	// first sample after release still shows the reset values
	chk_reset_pins_off: assert property ($rose(i_rst_b) |->
		!(o_memory_select_out_oe | o_memory_serial_clock_oe |
		o_memory_serial_line_oe)) else $error("memory pins driven");
	chk_reset_fifo_pullup: assert property ($rose(i_rst_b) |->
		!o_fifo_drive_enable && !o_pullup_drive_output_n)
		else $error("fifo or pull-up driven");
	chk_start_bit_first: assert property (
		$rose(o_memory_select_out) |->
		o_memory_serial_line && o_memory_serial_line_oe &&
		!o_memory_serial_clock) else $error("bad start bit");
	chk_clock_half_period: assert property (
		$rose(o_memory_serial_clock) && o_memory_serial_line_oe |->
		##25 $fell(o_memory_serial_clock)) else $error("clock high time");
	chk_ack_line_released: assert property (
		$fell(o_memory_serial_line_oe) && o_memory_select_out |->
		!o_memory_serial_line_oe [*8]) else $error("line driven in reply");
	chk_select_gap_low: assert property (
		$fell(o_memory_select_out) |->
		!o_memory_select_out [*8]) else $error("select gap too short");
	chk_default_config_used: assert property (
		$rose(o_load_done) && !o_config_from_memory |->
		o_config == DEFAULT_CONFIG) else $error("defaults not applied");
	chk_config_holds: assert property ($rose(o_load_done) |=>
		$stable(o_config) [*8]) else $error("config moved after load");
	cover property ($rose(o_load_done) && o_config_from_memory);
	cover property ($rose(o_load_done) && !o_config_from_memory);
	cover property ($fell(o_memory_serial_line_oe));
endmodule : serial_eeprom_config_loader_checker

bind serial_eeprom_config_loader serial_eeprom_config_loader_checker i_chk (
	.i_clock                  (i_clock),
	.i_rst_b                  (i_rst_b),
	.o_memory_serial_line     (o_memory_serial_line),
	.o_memory_serial_line_oe  (o_memory_serial_line_oe),
	.o_memory_select_out      (o_memory_select_out),
	.o_memory_select_out_oe   (o_memory_select_out_oe),
	.o_memory_serial_clock    (o_memory_serial_clock),
	.o_memory_serial_clock_oe (o_memory_serial_clock_oe),
	.o_pullup_drive_output_n  (o_pullup_drive_output_n),
	.o_fifo_drive_enable      (o_fifo_drive_enable),
	.o_config                 (o_config),
	.o_config_from_memory     (o_config_from_memory),
	.o_load_done              (o_load_done)
);

// File: tb/config_memory_model.sv
`timescale 1ns/1ns
module config_memory_model
	import serial_eeprom_config_pkg::*;
(
	input  wire logic       i_select,
	input  wire logic       i_serial_clock,
	input  wire logic       i_line,
	input  wire logic       i_present,
	input  wire config_type i_image,
	output logic            o_data,
	output logic            o_drive
);
	int         count;
	int         addr;
	logic [7:0] cmd;
	// ====================================================
	// sixteen-bit word memory, edge driven so any rate works
	initial begin
		o_data = 1'b1;
		o_drive = 1'b0;
	end
	always @(posedge i_select) count = 0;
	always @(negedge i_select) o_drive = 1'b0;
	always @(posedge i_serial_clock) begin
		if (i_select) begin
			if (count == 8) begin
				addr = {cmd[4:0], i_line} % 4;
				// absent part or bad opcode never answers
				o_drive = i_present && cmd[7:5] == 3'b110;
				o_data = 1'b0;
			end else if (count >= 9 && count <= 24)
				o_data = i_image[(3 - addr) * 16 + 24 - count];
			else if (count == 25)
				o_drive = 1'b0;
			cmd = {cmd[6:0], i_line};
			count++;
		end
	end
endmodule : config_memory_model

// File: tb/serial_eeprom_config_loader_bench.sv
`timescale 1ns/1ns
module serial_eeprom_config_loader_bench;
	import serial_eeprom_config_pkg::*;
	localparam config_type GOOD = '{VALID_MARKER, 16'hC3E1, 16'h0064, 16'h0123};
	localparam config_type BAD  = '{16'hA55B, 16'h0001, 16'h0002, 16'h0003};
	// self-powered image keeps a zero power word
	localparam config_type SELF = '{VALID_MARKER, 16'h0F0F, 16'h0000, 16'h0040};
	// send-now pin unused on this board, so tied high
	wire        send_now_wake_input = 1'b1;
	logic       i_clock = 1'b0, i_rst_b = 1'b0, i_bus_reset = 1'b0;
	logic       present = 1'b1, mem_data, mem_drive;
	config_type load_image = GOOD, o_config;
	logic       o_memory_serial_line, o_memory_serial_line_oe;
	logic       o_memory_select_out, o_memory_select_out_oe;
	logic       o_memory_serial_clock, o_memory_serial_clock_oe;
	logic       o_pullup_drive_output_n, o_fifo_drive_enable;
	logic       o_config_from_memory, o_load_done;
	int         mismatches = 0, tests_run = 0, cycles = 0;
	// ====================================================
	// pins have pull-ups, so released lines read high
	wire sel_w = o_memory_select_out_oe ? o_memory_select_out : 1'b1;
	wire sk_w = o_memory_serial_clock_oe ? o_memory_serial_clock : 1'b1;
	wire i_memory_serial_line = o_memory_serial_line_oe ?
		o_memory_serial_line : (mem_drive ? mem_data : 1'b1);
	serial_eeprom_config_loader i_dut (
		.i_clock                  (i_clock),
		.i_rst_b                  (i_rst_b),
		.i_bus_reset              (i_bus_reset),
		.i_memory_serial_line     (i_memory_serial_line),
		.o_memory_serial_line     (o_memory_serial_line),
		.o_memory_serial_line_oe  (o_memory_serial_line_oe),
		.o_memory_select_out      (o_memory_select_out),
		.o_memory_select_out_oe   (o_memory_select_out_oe),
		.o_memory_serial_clock    (o_memory_serial_clock),
		.o_memory_serial_clock_oe (o_memory_serial_clock_oe),
		.o_pullup_drive_output_n  (o_pullup_drive_output_n),
		.o_fifo_drive_enable      (o_fifo_drive_enable),
		.o_config                 (o_config),
		.o_config_from_memory     (o_config_from_memory),
		.o_load_done              (o_load_done)
	);
	config_memory_model i_mem (.i_select(sel_w), .i_serial_clock(sk_w),
		.i_line(i_memory_serial_line), .i_present(present),
		.i_image(load_image), .o_data(mem_data), .o_drive(mem_drive));
	initial forever #10 i_clock = ~i_clock;
	// ====================================================
	// compare and closing
	task check(string what, logic [63:0] exp, logic [63:0] got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task end_sim;
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			end_sim();
		end
	end
	// ====================================================
	// scenarios
	task finish_load(config_type exp, logic exp_mem);
		int n;
		n = 0;
		// look off the edge so the flag is settled when read
		while (o_load_done !== 1'b1 && n < 9000) begin
			@(posedge i_clock);
			#1;
			n++;
		end
		check("done", 1'b1, o_load_done);
		check("config", exp, o_config);
		check("source", exp_mem, o_config_from_memory);
	endtask : finish_load
	task bus_load(config_type img, logic here, config_type exp, logic exp_mem);
		load_image = img;
		present = here;
		@(posedge i_clock) #1 i_bus_reset = 1'b1;
		repeat (5) @(posedge i_clock);
		#1 i_bus_reset = 1'b0;
		check("done cleared", 1'b0, o_load_done);
		finish_load(exp, exp_mem);
	endtask : bus_load
	task shared_access;
		present = 1'b1;
		@(posedge i_clock) #1 i_bus_reset = 1'b1;
		repeat (600) @(posedge i_clock);
		#1 i_rst_b = 1'b0;
		i_bus_reset = 1'b0;
		repeat (3) @(posedge i_clock);
		#1;
		check("pins", 3'h0, {o_memory_select_out_oe,
			o_memory_serial_clock_oe, o_memory_serial_line_oe});
		check("fifo", 1'b0, o_fifo_drive_enable);
		check("pullup", 1'b0, o_pullup_drive_output_n);
		load_image = SELF;
		i_rst_b = 1'b1;
		finish_load(SELF, 1'b1);
		check("fifo on", 1'b1, o_fifo_drive_enable);
		check("pullup on", 1'b1, o_pullup_drive_output_n);
	endtask : shared_access
	initial begin
		repeat (2) @(posedge i_clock);
		#1 i_rst_b = 1'b1;
		finish_load(GOOD, 1'b1);
		bus_load(GOOD, 1'b0, DEFAULT_CONFIG, 1'b0);
		bus_load(BAD, 1'b1, DEFAULT_CONFIG, 1'b0);
		shared_access();
		end_sim();
	end
endmodule : serial_eeprom_config_loader_bench
